// [design/dws_consts.svh]
`ifndef DWS_CONSTS_SVH
`define DWS_CONSTS_SVH

// register byte offsets on the control bus
`define DWS_OFS_STATUS   8'h00
`define DWS_OFS_TXDATA   8'h04
`define DWS_OFS_RXDATA   8'h08
`define DWS_OFS_MODEM    8'h0c
`define DWS_OFS_USBST    8'h10
`define DWS_OFS_NVADDR   8'h14
`define DWS_OFS_NVDATA   8'h18

// status register fields
`define DWS_ST_TXVALID   0
`define DWS_ST_RXFULL    1
`define DWS_ST_FLUSH     2
`define DWS_ST_ACTIVE    3

// command word bit positions
`define DWS_CW_CMD3      0
`define DWS_CW_CMD2      3
`define DWS_CW_CMD1      5
`define DWS_CW_CMD0      6

// command codes
`define DWS_CMD_WRITE    4'h0
`define DWS_CMD_READ     4'h1
`define DWS_CMD_MSRD     4'h2
`define DWS_CMD_MSWR     4'h3
`define DWS_CMD_FLUSH    4'h4
`define DWS_CMD_NVADDR   4'h5
`define DWS_CMD_NVWR     4'h6
`define DWS_CMD_NVRD     4'h7
`define DWS_CMD_USBST    4'h8

// configuration byte kept at nonvolatile address zero
`define DWS_NV_CFG_ADDR  8'h00
`define DWS_CFG_CPOL     0
`define DWS_CFG_LSB      1
`define DWS_CFG_STATEN   2
`define DWS_CFG_RST      8'h04

// bus responses
`define DWS_RESP_OKAY    2'h0
`define DWS_RESP_SLVERR  2'h2

`endif

// [design/dws_pkg.sv]
package dws_pkg;

  // transfer width, index is log2 of the lane count
  typedef enum logic [1:0] {DWS_W1, DWS_W2, DWS_W4, DWS_W8} dws_width_e;

  // link sequencer states
  typedef enum logic [1:0] {DWS_IDLE, DWS_CMD, DWS_DATA} dws_state_e;

  // lanes carrying one beat of a byte
  function automatic logic [7:0] dws_lanes(input dws_width_e w);
    return 8'((9'h001 << (4'd1 << w)) - 9'h001);
  endfunction

  // bits of the current beat, right aligned on the lanes
  function automatic logic [7:0] dws_beat(input logic [7:0] b, input dws_width_e w,
                                          input logic lsb);
    return lsb ? (b & dws_lanes(w)) : 8'(b >> (4'd8 - (4'd1 << w)));
  endfunction

  // drop the beat just sent
  function automatic logic [7:0] dws_drop(input logic [7:0] b, input dws_width_e w,
                                          input logic lsb);
    return lsb ? 8'(b >> (4'd1 << w)) : 8'(b << (4'd1 << w));
  endfunction

  // merge a received beat into the byte being built
  function automatic logic [7:0] dws_merge(input logic [7:0] b, input logic [7:0] d,
                                           input dws_width_e w, input logic lsb);
    logic [7:0] m;
    m = d & dws_lanes(w);
    return lsb ? (8'(b >> (4'd1 << w)) | 8'(m << (4'd8 - (4'd1 << w))))
               : (8'(b << (4'd1 << w)) | m);
  endfunction

endpackage

// [design/dws_slave.sv]
`include "dws_consts.svh"

module dws_slave
  import dws_pkg::*;
#(
  parameter int NV_DEPTH = 256  // nonvolatile bytes
)(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // control bus
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // link pins
  input  wire logic        link_sclk,
  input  wire logic        link_sel_n,
  input  wire logic [7:0]  bidir_data_lines_in,
  output logic [7:0]       bidir_data_lines_out,
  output logic [7:0]       bidir_data_lines_oe,
  output logic [7:0]       bidir_data_lines_pu,
  output logic             link_miso,
  output logic             link_miso_oe,
  // upstream
  output logic             flush_req
);

  // pin synchronisers, three stages each
  logic [2:0]  sclk_sy;                 // clock samples
  logic [2:0]  sel_sy;                  // select samples
  logic [7:0]  d_s1, d_s2, d_s3;        // data samples
  logic        sclk_f, sclk_q;          // agreed clock level and its last value
  logic        sel_f;                   // agreed select level
  logic [7:0]  d_f;                     // agreed data lines

  // link sequencer
  dws_state_e  state;                   // link phase
  dws_width_e  width;                   // width of this transfer
  logic [3:0]  cmd;                     // command of this transfer
  logic [2:0]  beat;                    // beat within the byte
  logic [7:0]  sh;                      // byte shift register
  logic        ack;                     // answer given for the current byte
  logic        cfg_cpol;                // active idle level
  logic        cfg_lsb;                 // active bit order
  logic        cfg_staten;              // idle status enable

  // pulses from the sequencer to the register side
  logic        put_rx, take_tx, put_ms, put_na, put_nw, put_fl;
  logic [7:0]  put_byte;                // byte that goes with a pulse

  // software visible state
  logic [7:0]  rx_data;                 // last byte written by the master
  logic        rx_full;                 // rx_data not yet read
  logic [7:0]  tx_data;                 // byte offered to the master
  logic        tx_valid;                // tx_data not yet taken
  logic        flush_seen;              // sticky flush flag
  logic [1:0]  ms_out;                  // dtr, rts
  logic [3:0]  ms_in;                   // dcd, ri, dsr, cts
  logic [1:0]  usb_state;               // suspended, default, addressed, configured
  logic [7:0]  sw_nv_addr;              // software pointer into nonvolatile store
  logic [7:0]  link_nv_addr;            // link pointer into nonvolatile store
  logic [7:0]  nv_cfg;                  // configuration byte at address zero
  logic [7:0]  nv_mem [NV_DEPTH];       // rest of the nonvolatile store

  // bus helpers
  logic [7:0]  aw_addr;                 // captured write address
  logic [31:0] w_data;                  // captured write data
  logic [3:0]  w_strb;                  // captured byte enables
  logic        do_wr;                   // both halves held, commit now
  logic        rd_hit;                  // read address taken this cycle

  // edge and byte helpers
  logic        lead, trail;             // driving and sampling clock edges
  logic        last_beat;               // beat closes the byte
  logic        sending;                 // command returns data
  logic        receiving;               // command carries data in
  logic [7:0]  src_byte;                // byte to send for this command
  logic        ack_now;                 // answer for a byte about to start
  logic [7:0]  nsh;                     // shift register after a received beat

  // nonvolatile read helper
  function automatic logic [7:0] nv_read(input logic [7:0] a);
    if (a == `DWS_NV_CFG_ADDR)
      return nv_cfg;
    else if (32'(a) < NV_DEPTH)
      return nv_mem[a];
    else
      return 8'h00;
  endfunction

  // a change counts once the second and third stage agree
  always_ff @(posedge sys_clk)
  begin
    sclk_sy <= {sclk_sy[1:0], link_sclk};
    sel_sy  <= {sel_sy[1:0], link_sel_n};
    d_s1    <= bidir_data_lines_in;
    d_s2    <= d_s1;
    d_s3    <= d_s2;
    if (!rst_n)
    begin
      sclk_f <= 1'b0;
      sclk_q <= 1'b0;
      sel_f  <= 1'b1;
      d_f    <= 8'hff;
    end
    else
    begin
      if (sclk_sy[1] == sclk_sy[2])
        sclk_f <= sclk_sy[2];
      sclk_q <= sclk_f;
      if (sel_sy[1] == sel_sy[2])
        sel_f <= sel_sy[2];
      d_f <= (d_s2 & d_s3) | (d_f & (d_s2 ^ d_s3));
    end
  end

  // the clock is only sampled, so any master rate below a few system clocks works
  // leaving the idle level drives, returning to it samples
  assign lead  = (sclk_f != sclk_q) && (sclk_q == cfg_cpol);
  assign trail = (sclk_f != sclk_q) && (sclk_q != cfg_cpol);

  assign last_beat = (beat == 3'((4'd8 >> width) - 4'd1));
  assign sending   = (cmd == `DWS_CMD_READ) || (cmd == `DWS_CMD_MSRD)
                  || (cmd == `DWS_CMD_NVRD) || (cmd == `DWS_CMD_USBST);
  assign receiving = (cmd == `DWS_CMD_WRITE) || (cmd == `DWS_CMD_MSWR)
                  || (cmd == `DWS_CMD_NVADDR) || (cmd == `DWS_CMD_NVWR);
  assign nsh = dws_merge(sh, d_f, width, cfg_lsb);

  // data the device returns per command
  always_comb
  begin
    case (cmd)
      `DWS_CMD_READ:  src_byte = tx_data;
      `DWS_CMD_MSRD:  src_byte = {6'h00, ms_out};
      `DWS_CMD_NVRD:  src_byte = nv_read(link_nv_addr);
      `DWS_CMD_USBST: src_byte = {6'h00, usb_state};
      default:        src_byte = 8'h00;
    endcase
  end

  // nak when the byte cannot move or the code is unused
  always_comb
  begin
    case (cmd)
      `DWS_CMD_WRITE: ack_now = !rx_full;
      `DWS_CMD_READ:  ack_now = tx_valid;
      default:        ack_now = (cmd <= `DWS_CMD_USBST);
    endcase
  end

  // link sequencer, pins and byte pulses
  always_ff @(posedge sys_clk)
  begin
    put_rx  <= 1'b0;
    take_tx <= 1'b0;
    put_ms  <= 1'b0;
    put_na  <= 1'b0;
    put_nw  <= 1'b0;
    put_fl  <= 1'b0;
    if (!rst_n)
    begin
      state                <= DWS_IDLE;
      width                <= DWS_W1;
      cmd                  <= 4'h0;
      beat                 <= 3'h0;
      sh                   <= 8'h00;
      ack                  <= 1'b0;
      put_byte             <= 8'h00;
      cfg_cpol             <= 1'b0;
      cfg_lsb              <= 1'b0;
      cfg_staten           <= 1'b0;
      bidir_data_lines_out <= 8'h00;
      bidir_data_lines_oe  <= 8'h00;
      bidir_data_lines_pu  <= 8'h00;
      link_miso            <= 1'b0;
      link_miso_oe         <= 1'b0;
    end
    else
    begin
      bidir_data_lines_pu <= 8'hff;
      if (sel_f)
      begin
        // select high: abort anything, reload configuration, show status
        state      <= DWS_IDLE;
        cfg_cpol   <= nv_cfg[`DWS_CFG_CPOL];
        cfg_lsb    <= nv_cfg[`DWS_CFG_LSB];
        cfg_staten <= nv_cfg[`DWS_CFG_STATEN];
        // off keeps shared buses free of contention
        link_miso_oe               <= nv_cfg[`DWS_CFG_STATEN];
        link_miso                  <= tx_valid;
        bidir_data_lines_oe        <= {7'h00, nv_cfg[`DWS_CFG_STATEN]};
        bidir_data_lines_out       <= {7'h00, !rx_full};
      end
      else
      begin
        case (state)
          DWS_IDLE:
          begin
            // release line 0 at once so the bus turns before the first edge
            bidir_data_lines_oe <= 8'h00;
            link_miso_oe        <= 1'b0;
            state               <= DWS_CMD;
          end
          DWS_CMD:
          begin
            if (trail)
            begin
              // whole command word sampled eight wide
              cmd <= {d_f[`DWS_CW_CMD3], d_f[`DWS_CW_CMD2],
                      d_f[`DWS_CW_CMD1], d_f[`DWS_CW_CMD0]};
              // lines 0, 3, 5 and 6 carry command bits, so only flag lines 4, 2, 1 pick width
              if (!d_f[4])
                width <= DWS_W8;
              else if (!d_f[2])
                width <= DWS_W4;
              else if (!d_f[1])
                width <= DWS_W2;
              else
                width <= DWS_W1;
              if ({d_f[0], d_f[3], d_f[5], d_f[6]} == `DWS_CMD_FLUSH)
                put_fl <= 1'b1;
              beat  <= 3'h0;
              state <= DWS_DATA;
            end
          end
          DWS_DATA:
          begin
            if (lead)
            begin
              if (beat == 3'h0)
              begin
                // answer for the byte that starts now
                ack          <= ack_now;
                link_miso    <= ack_now;
                link_miso_oe <= 1'b1;
                if (sending && ack_now)
                begin
                  bidir_data_lines_out <= dws_beat(src_byte, width, cfg_lsb);
                  bidir_data_lines_oe  <= dws_lanes(width);
                  sh                   <= dws_drop(src_byte, width, cfg_lsb);
                end
                else
                  bidir_data_lines_oe <= 8'h00;
              end
              else if (sending && ack)
              begin
                bidir_data_lines_out <= dws_beat(sh, width, cfg_lsb);
                sh                   <= dws_drop(sh, width, cfg_lsb);
              end
            end
            if (trail)
            begin
              if (receiving)
                sh <= nsh;
              if (last_beat)
              begin
                beat     <= 3'h0;
                put_byte <= nsh;
                if (ack)
                begin
                  put_rx  <= (cmd == `DWS_CMD_WRITE);
                  take_tx <= (cmd == `DWS_CMD_READ);
                  put_ms  <= (cmd == `DWS_CMD_MSWR);
                  put_na  <= (cmd == `DWS_CMD_NVADDR);
                  put_nw  <= (cmd == `DWS_CMD_NVWR);
                end
              end
              else
                beat <= beat + 3'h1;
            end
          end
          default:
            state <= DWS_IDLE;
        endcase
      end
    end
  end

  // write channel: hold address and data, commit once both are in
  assign do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DWS_RESP_OKAY;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr)
      begin
        s_axi_bvalid <= 1'b1;
        case (aw_addr)
          `DWS_OFS_STATUS, `DWS_OFS_TXDATA, `DWS_OFS_RXDATA, `DWS_OFS_MODEM,
          `DWS_OFS_USBST, `DWS_OFS_NVADDR, `DWS_OFS_NVDATA:
            s_axi_bresp <= `DWS_RESP_OKAY;
          default:
            s_axi_bresp <= `DWS_RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read channel, one outstanding read
  assign rd_hit = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `DWS_RESP_OKAY;
    end
    else if (rd_hit)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `DWS_RESP_OKAY;
      case (s_axi_araddr)
        `DWS_OFS_STATUS: s_axi_rdata <= {24'h0, 2'h0, width, !sel_f, flush_seen,
                                         rx_full, tx_valid};
        `DWS_OFS_TXDATA: s_axi_rdata <= {24'h0, tx_data};
        `DWS_OFS_RXDATA: s_axi_rdata <= {24'h0, rx_data};
        `DWS_OFS_MODEM:  s_axi_rdata <= {24'h0, ms_in, 2'h0, ms_out};
        `DWS_OFS_USBST:  s_axi_rdata <= {30'h0, usb_state};
        `DWS_OFS_NVADDR: s_axi_rdata <= {24'h0, sw_nv_addr};
        `DWS_OFS_NVDATA: s_axi_rdata <= {24'h0, nv_read(sw_nv_addr)};
        default:
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `DWS_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // mailbox bytes; a new event beats a clear in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rx_data    <= 8'h00;
      rx_full    <= 1'b0;
      tx_data    <= 8'h00;
      tx_valid   <= 1'b0;
      flush_seen <= 1'b0;
      flush_req  <= 1'b0;
    end
    else
    begin
      flush_req <= put_fl;
      if (put_rx)
      begin
        rx_data <= put_byte;
        rx_full <= 1'b1;
      end
      else if (rd_hit && s_axi_araddr == `DWS_OFS_RXDATA)
        rx_full <= 1'b0;
      if (do_wr && aw_addr == `DWS_OFS_TXDATA && w_strb[0])
      begin
        tx_data  <= w_data[7:0];
        tx_valid <= 1'b1;
      end
      else if (take_tx)
        tx_valid <= 1'b0;
      if (put_fl)
        flush_seen <= 1'b1;
      else if (do_wr && aw_addr == `DWS_OFS_STATUS && w_strb[0] && w_data[`DWS_ST_FLUSH])
        flush_seen <= 1'b0;
    end
  end

  // modem emulation, usb state and nonvolatile pointers
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ms_out       <= 2'h0;
      ms_in        <= 4'h0;
      usb_state    <= 2'h0;
      sw_nv_addr   <= 8'h00;
      link_nv_addr <= 8'h00;
    end
    else
    begin
      if (put_ms)
        ms_in <= put_byte[3:0];
      if (put_na)
        link_nv_addr <= put_byte;
      if (do_wr && w_strb[0])
      begin
        case (aw_addr)
          `DWS_OFS_MODEM:  ms_out     <= w_data[1:0];
          `DWS_OFS_USBST:  usb_state  <= w_data[1:0];
          `DWS_OFS_NVADDR: sw_nv_addr <= w_data[7:0];
          default:         ;
        endcase
      end
    end
  end

  // nonvolatile store; the link write wins a same-cycle collision
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      nv_cfg <= `DWS_CFG_RST;
    else if (put_nw && link_nv_addr == `DWS_NV_CFG_ADDR)
      nv_cfg <= put_byte;
    else if (!put_nw && do_wr && aw_addr == `DWS_OFS_NVDATA && w_strb[0]
             && sw_nv_addr == `DWS_NV_CFG_ADDR)
      nv_cfg <= w_data[7:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (put_nw && 32'(link_nv_addr) < NV_DEPTH)
      nv_mem[link_nv_addr] <= put_byte;
    else if (do_wr && aw_addr == `DWS_OFS_NVDATA && w_strb[0]
             && 32'(sw_nv_addr) < NV_DEPTH)
      nv_mem[sw_nv_addr] <= w_data[7:0];
  end

endmodule

// [test/dws_slave_checker.sv]
module dws_slave_checker (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       link_sel_n,
  input wire logic [7:0] bidir_data_lines_out,
  input wire logic [7:0] bidir_data_lines_oe,
  input wire logic [7:0] bidir_data_lines_pu,
  input wire logic       link_miso,
  input wire logic       link_miso_oe,
  input wire logic       flush_req
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // pull-ups stay on once reset is gone
  AST_PULLUP: assert property ($past(rst_n, 2) |-> bidir_data_lines_pu == 8'hff)
    else $error("pull-ups off");
  // select low frees line 0 and miso before the first edge
  AST_RELEASE: assert property ($fell(link_sel_n) |-> ##[1:6]
    (!bidir_data_lines_oe[0] && !link_miso_oe)) else $error("no turnaround");
  AST_LANES: assert property (bidir_data_lines_oe inside
    {8'h00, 8'h01, 8'h03, 8'h0f, 8'hff}) else $error("bad lane set");
  AST_IDLE_LANES: assert property (link_sel_n [*6] |->
    bidir_data_lines_oe[7:1] == 7'h00) else $error("lanes driven idle");
  AST_FLUSH_PULSE: assert property (flush_req |=> !flush_req)
    else $error("flush too long");
  AST_FLUSH_SEL: assert property (flush_req |-> !$past(link_sel_n, 4))
    else $error("flush outside frame");
  // a refused byte must not put data on the lanes
  AST_NAK_QUIET: assert property (!link_sel_n && !$past(link_sel_n, 8) && link_miso_oe
    && !link_miso |-> bidir_data_lines_oe == 8'h00) else $error("data on nak");
  // upper lanes only move on link edges inside a frame or when they clear as select returns high
  AST_OUT_FRAME: assert property ($changed(bidir_data_lines_out[7:1]) |->
    !$past(link_sel_n, 6)) else $error("lane change idle");
endmodule

// [test/dws_master_model.sv]
module dws_master_model (
  output logic       link_sclk,
  output logic       link_sel_n,
  output logic [7:0] bidir_data_lines_in,
  input  wire logic [7:0] bidir_data_lines_out,
  input  wire logic [7:0] bidir_data_lines_oe,
  input  wire logic       link_miso,
  input  wire logic       link_miso_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       cpol = 1'b0; // idle clock level
  logic       lsb  = 1'b0; // bit order
  logic [7:0] md   = 8'h00; // master value
  logic [7:0] men  = 8'h00; // master enable
  // released lines float high through the pull-ups
  assign bidir_data_lines_in = (bidir_data_lines_oe & bidir_data_lines_out) |
    (~bidir_data_lines_oe & ((men & md) | ~men));
  initial
  begin
    link_sclk  = 1'b0;
    link_sel_n = 1'b1;
  end
  // one frame: command word then n bytes of 8/w beats
  task frame(input logic [3:0] c, input int w, n, input logic wr, input logic [7:0] wb,
             output logic [7:0] rb, output logic [7:0] ack);
    logic [7:0] m;
    m = 8'((1 << w) - 1);
    ack = 8'h00;
    rb = 8'h00;
    link_sclk <= cpol;
    #62.5 link_sel_n <= 1'b0;
    #62.5 link_sclk <= ~cpol;
    md  <= {1'b1, c[0], c[1], 1'b0, c[2], 2'b00, c[3]};
    men <= 8'h69 | 8'(w == 8 ? 16 : w & 6);
    #62.5 link_sclk <= cpol;
    for (int b = 0; b < n; b++)
    begin
      for (int k = 0; k < 8 / w; k++)
      begin
        #62.5 link_sclk <= ~cpol;
        men <= wr ? m : 8'h00;
        md  <= 8'(lsb ? wb >> (k * w) : wb >> (8 - (k + 1) * w));
        #62.5 link_sclk <= cpol;
        if (k == 0) ack[b] = link_miso & link_miso_oe;
        if (k == 0) rb = 8'h00;
        rb = lsb ? rb | 8'((bidir_data_lines_in & m) << (k * w))
                 : 8'(rb << w) | (bidir_data_lines_in & m);
      end
      if (!ack[b]) break;
    end
    #62.5 men <= 8'h00;
    link_sel_n <= 1'b1;
    #125;
  endtask
endmodule

// [test/dws_slave_tb_top.sv]
`include "dws_consts.svh"

module dws_slave_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk = 1'b0, rst_n = 1'b0, s_axi_bready = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        link_sclk, link_sel_n, link_miso, link_miso_oe, flush_req;
  logic [7:0]  bidir_data_lines_in, bidir_data_lines_out, bidir_data_lines_oe;
  logic [7:0]  bidir_data_lines_pu, rb, ak;
  int          err_count = 0, num_checks = 0, flushes = 0;
  dws_slave u_dws_slave (.*);
  dws_master_model u_dws_master_model (.*);
  always #5 sys_clk = ~sys_clk;
  // count flush pulses seen upstream
  always @(posedge sys_clk) if (flush_req === 1'b1) flushes++;
  task chk(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, a > 8'h18 ? 2'h2 : 2'h0);
  endtask
  task rd(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk("rresp", s_axi_rresp, a > 8'h18 ? 2'h2 : 2'h0);
  endtask
  task lk(input logic [3:0] c, input int w, n, input logic wrt, input logic [7:0] wb);
    u_dws_master_model.frame(c, w, n, wrt, wb, rb, ak);
  endtask
  task t_idle();
    repeat (8) @(posedge sys_clk);
    chk("pu", bidir_data_lines_pu, 8'hff);
    chk("miso idle", {link_miso_oe, link_miso}, 2'b10);
    chk("line0", {bidir_data_lines_oe[0], bidir_data_lines_out[0]}, 2'b11);
    rd(`DWS_OFS_STATUS);
    chk("status", rv, 32'h0);
    rd(8'h40);
    wr(8'h40, 32'h0);
    wr(`DWS_OFS_NVADDR, 32'h0);
    rd(`DWS_OFS_NVDATA);
    chk("config", rv[7:0], `DWS_CFG_RST);
    $display("test idle done");
  endtask
  // every width, second byte refused because the receive slot is full
  task t_width();
    for (int i = 0; i < 4; i++)
    begin
      lk(`DWS_CMD_WRITE, 1 << i, 2, 1, 8'h3c + i);
      chk("ack", ak, 8'h01);
      rd(`DWS_OFS_STATUS);
      chk("width", rv, 32'h2 | (i << 4));
      rd(`DWS_OFS_RXDATA);
      chk("rxdata", rv[7:0], 8'h3c + i);
    end
    $display("test width done");
  endtask
  // lsb first, idle-high clock, idle status off
  task t_cfg();
    logic [7:0] cf;
    for (int i = 0; i < 3; i++)
    begin
      cf = i == 0 ? 8'h06 : (i == 1 ? 8'h05 : 8'h00);
      wr(`DWS_OFS_NVDATA, cf);
      u_dws_master_model.lsb = cf[1];
      u_dws_master_model.cpol = cf[0];
      wr(`DWS_OFS_TXDATA, 32'h96);
      lk(`DWS_CMD_READ, 2, 1, 0, 8'h00);
      chk("rd byte", rb, 8'h96);
      lk(`DWS_CMD_WRITE, 1, 1, 1, 8'h4d);
      rd(`DWS_OFS_RXDATA);
      chk("wr byte", rv[7:0], 8'h4d);
      chk("idle en", link_miso_oe, cf[2]);
    end
    wr(`DWS_OFS_NVDATA, 32'h04);
    $display("test cfg done");
  endtask
  task t_cmds();
    wr(`DWS_OFS_MODEM, 32'h2);
    lk(`DWS_CMD_MSRD, 8, 1, 0, 8'h00);
    chk("modem rd", rb[1:0], 2'h2);
    lk(`DWS_CMD_MSWR, 8, 1, 1, 8'h0a);
    rd(`DWS_OFS_MODEM);
    chk("modem", rv, 32'ha2);
    for (int u = 0; u < 4; u++)
    begin
      wr(`DWS_OFS_USBST, u);
      lk(`DWS_CMD_USBST, 4, 1, 0, 8'h00);
      chk("usb", rb[1:0], u);
    end
    lk(`DWS_CMD_NVADDR, 8, 1, 1, 8'h03);
    lk(`DWS_CMD_NVWR, 8, 1, 1, 8'h5c);
    wr(`DWS_OFS_NVADDR, 32'h3);
    rd(`DWS_OFS_NVDATA);
    chk("nv wr", rv[7:0], 8'h5c);
    lk(`DWS_CMD_NVRD, 8, 1, 0, 8'h00);
    chk("nv rd", rb, 8'h5c);
    flushes = 0;
    lk(`DWS_CMD_FLUSH, 8, 0, 0, 8'h00);
    rd(`DWS_OFS_STATUS);
    chk("flush", {flushes[3:0], rv[2]}, 5'h3);
    wr(`DWS_OFS_STATUS, 32'h4);
    rd(`DWS_OFS_STATUS);
    chk("flush clr", rv[2], 1'b0);
    lk(`DWS_CMD_READ, 8, 1, 0, 8'h00);
    chk("nak empty", ak, 8'h0);
    for (int c = 9; c < 16; c++)
    begin
      lk(4'(c), 8, 1, 1, 8'h11);
      chk("reserved", ak, 8'h0);
    end
    $display("test cmds done");
  endtask
  task results();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_idle();
    t_width();
    t_cfg();
    t_cmds();
    results();
  end
  // hang guard, well past the expected run length
  initial
  begin
    #400us;
    err_count++;
    results();
  end
endmodule

bind dws_slave dws_slave_checker u_dws_slave_checker (.*);
